// *** atb_timebase.sv ***
`default_nettype none
`include "atb_params.svh"
module atb_timebase
    import atb_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Pins and neighbouring logic
    input  wire logic [3:0]  channel_pin_i,
    input  wire logic        external_trigger_pin_i,
    input  wire logic [3:0]  internal_trigger_input_i,
    input  wire logic        capture_compare_event_i,
    input  wire logic        break_event_i,
    // Time base outputs
    output logic [15:0]      count_value_o,
    output logic             count_down_o,
    output logic             overrun_o,
    output logic             underrun_o,
    output logic             update_event_o,
    output logic             trigger_interrupt_o,
    output logic             capture_compare_interrupt_o,
    output logic             break_interrupt_o,
    output logic             slave_trigger_input_o,
    output logic             channel_one_double_edge_o,
    output logic [3:0]       filtered_polarised_input_o,
    output logic             external_trigger_filtered_o
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [3:0]  ctrl;
    logic [14:0] smc;
    logic [7:0]  chcfg;
    logic [3:0]  sts;
    logic [15:0] cnt;
    logic [15:0] psc_pre;
    logic [15:0] psc_act;
    logic [15:0] psc_cnt;
    logic [15:0] arr_pre;
    logic [15:0] arr_act;
    logic [7:0]  rep_pre;
    logic [7:0]  rep_act;
    logic [7:0]  rep_cnt;
    logic        dir;
    logic        wr;
    logic        sw_ug;
    logic        sw_tg;
    logic [31:0] cnt_wr;
    logic [31:0] smc_wr;
    logic [31:0] psc_wr;
    logic [31:0] arr_wr;
    logic [31:0] next_dat;

    atb_slave_mode_e sm;
    atb_trig_sel_e   ts;
    assign sm = atb_slave_mode_e'(smc[`ATB_SMC_SM]);
    assign ts = atb_trig_sel_e'(smc[`ATB_SMC_TS]);

    // ----------------------------------------
    // Wishbone access
    // ----------------------------------------
    // Answer one cycle after the strobe; unmapped reads give zero
    assign wr    = cyc_i && stb_i && we_i && !ack_o;
    assign sw_ug = wr && adr_i == `ATB_OFS_EVGEN && sel_i[0] && dat_i[`ATB_EV_UG];
    assign sw_tg = wr && adr_i == `ATB_OFS_EVGEN && sel_i[0] && dat_i[`ATB_EV_TG];

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Byte-merged write words, so partial writes keep untouched bytes
    assign cnt_wr = merge({16'h0, cnt}, dat_i, sel_i);
    assign smc_wr = merge({17'h0, smc}, dat_i, sel_i);
    assign psc_wr = merge({16'h0, psc_pre}, dat_i, sel_i);
    assign arr_wr = merge({16'h0, arr_pre}, dat_i, sel_i);

    always_comb begin
        case (adr_i)
            `ATB_OFS_CTRL:  next_dat = {27'h0, dir, ctrl};
            `ATB_OFS_SMC:   next_dat = {17'h0, smc};
            `ATB_OFS_CHCFG: next_dat = {24'h0, chcfg};
            `ATB_OFS_STS:   next_dat = {28'h0, sts};
            `ATB_OFS_CNT:   next_dat = {16'h0, cnt};
            `ATB_OFS_PSC:   next_dat = {16'h0, psc_pre};
            `ATB_OFS_ARR:   next_dat = {16'h0, arr_pre};
            `ATB_OFS_REP:   next_dat = {24'h0, rep_pre};
            default:        next_dat = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= next_dat;
        end
    end

    // ----------------------------------------
    // Pin synchronisers and filters
    // ----------------------------------------
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] lvl;
    logic [4:0] fin;
    logic [4:0] fout;
    logic [4:0] fout_q;
    logic [3:0] fcnt [5];
    logic       etr_p;
    logic       etr_p_q;
    logic [2:0] etr_div_cnt;
    logic       etr_div;

    assign etr_p = lvl[4] ^ smc[`ATB_SMC_ETP];
    always_comb begin
        case (smc[`ATB_SMC_ETPS])
            2'd0:    etr_div = etr_p;
            2'd1:    etr_div = etr_div_cnt[0];
            2'd2:    etr_div = etr_div_cnt[1];
            default: etr_div = etr_div_cnt[2];
        endcase
    end
    assign fin = {etr_div, lvl[3:0] ^ chcfg[`ATB_CH_POL]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            etr_p_q     <= 1'b0;
            etr_div_cnt <= 3'h0;
        end else begin
            etr_p_q <= etr_p;
            if (etr_p && !etr_p_q) begin
                etr_div_cnt <= etr_div_cnt + 3'h1;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            logic [3:0] flen;
            assign flen = (gi == 4) ? smc[`ATB_SMC_ETF] : chcfg[`ATB_CH_FILT];
            // Level taken only once the second and third stage agree
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1[gi]  <= 1'b0;
                    s2[gi]  <= 1'b0;
                    s3[gi]  <= 1'b0;
                    lvl[gi] <= 1'b0;
                end else begin
                    s1[gi] <= (gi == 4) ? external_trigger_pin_i : channel_pin_i[gi];
                    s2[gi] <= s1[gi];
                    s3[gi] <= s2[gi];
                    if (s2[gi] == s3[gi]) begin
                        lvl[gi] <= s3[gi];
                    end
                end
            end
            // Filter: new level must persist flen extra samples
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    fcnt[gi]   <= 4'h0;
                    fout[gi]   <= 1'b0;
                    fout_q[gi] <= 1'b0;
                end else begin
                    fout_q[gi] <= fout[gi];
                    if (fin[gi] == fout[gi]) begin
                        fcnt[gi] <= 4'h0;
                    end else if (fcnt[gi] >= flen) begin
                        fout[gi] <= fin[gi];
                        fcnt[gi] <= 4'h0;
                    end else begin
                        fcnt[gi] <= fcnt[gi] + 4'h1;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Trigger selection
    // ----------------------------------------
    logic ded;
    logic slave_trigger_input;
    logic slave_trigger_input_q;
    logic next_slave_trigger_input;
    logic trg_rise;

    always_comb begin
        case (ts)
            ATB_TS_ITR0: next_slave_trigger_input = internal_trigger_input_i[0];
            ATB_TS_ITR1: next_slave_trigger_input = internal_trigger_input_i[1];
            ATB_TS_ITR2: next_slave_trigger_input = internal_trigger_input_i[2];
            ATB_TS_ITR3: next_slave_trigger_input = internal_trigger_input_i[3];
            ATB_TS_DEDG: next_slave_trigger_input = ded;
            ATB_TS_CH1:  next_slave_trigger_input = fout[0];
            ATB_TS_CH2:  next_slave_trigger_input = fout[1];
            ATB_TS_CH3:  next_slave_trigger_input = fout[2];
            ATB_TS_CH4:  next_slave_trigger_input = fout[3];
            ATB_TS_EXTERNAL_TRIGGER_FILTERED: next_slave_trigger_input = fout[4];
            default:     next_slave_trigger_input = 1'b0;
        endcase
    end
    assign trg_rise = slave_trigger_input && !slave_trigger_input_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ded    <= 1'b0;
            slave_trigger_input   <= 1'b0;
            slave_trigger_input_q <= 1'b0;
        end else begin
            ded    <= fout[0] ^ fout_q[0];
            slave_trigger_input   <= next_slave_trigger_input;
            slave_trigger_input_q <= slave_trigger_input;
        end
    end

    // ----------------------------------------
    // Prescaler and slave control
    // ----------------------------------------
    logic prescaler_clock;
    logic gate;
    logic tick;
    logic slv_reset;
    logic slv_start;

    // Reset mode is the pulse measurement path, so it acts only on channel 1 and 2 triggers
    assign slv_reset = trg_rise && sm == ATB_SM_RESET
                       && (ts == ATB_TS_CH1 || ts == ATB_TS_CH2);
    assign slv_start = trg_rise && sm == ATB_SM_TRIG;
    assign gate = (sm != ATB_SM_GATED) || slave_trigger_input;
    always_comb begin
        if (sm == ATB_SM_EXT1) begin
            prescaler_clock = trg_rise;
        end else if (smc[`ATB_SMC_ECE]) begin
            prescaler_clock = fout[4] && !fout_q[4];
        end else begin
            prescaler_clock = 1'b1;
        end
    end
    assign tick = prescaler_clock && gate && ctrl[`ATB_CTRL_CEN] && psc_cnt >= psc_act;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    logic [15:0] next_cnt;
    logic        next_dir;
    logic        ovf;
    logic        udf;
    logic        reinit;
    logic        upd;

    always_comb begin
        next_cnt = cnt;
        next_dir = dir;
        ovf      = 1'b0;
        udf      = 1'b0;
        if (tick) begin
            if (!ctrl[`ATB_CTRL_CMS]) begin
                next_dir = ctrl[`ATB_CTRL_DIR];
                if (!ctrl[`ATB_CTRL_DIR]) begin
                    if (cnt == arr_act) begin
                        next_cnt = 16'h0;
                        ovf      = 1'b1;
                    end else begin
                        next_cnt = cnt + 16'h1;
                    end
                end else if (cnt == 16'h0) begin
                    next_cnt = arr_act;
                    udf      = 1'b1;
                end else begin
                    next_cnt = cnt - 16'h1;
                end
            end else if (arr_act != 16'h0) begin
                if (!dir) begin
                    ovf = (cnt == arr_act - 16'h1);
                    if (cnt >= arr_act) begin
                        next_dir = 1'b1;
                        next_cnt = cnt - 16'h1;
                    end else begin
                        next_cnt = cnt + 16'h1;
                    end
                end else begin
                    udf = (cnt == 16'h1);
                    if (cnt == 16'h0) begin
                        next_dir = 1'b0;
                        next_cnt = 16'h1;
                    end else begin
                        next_cnt = cnt - 16'h1;
                    end
                end
            end
        end
    end

    assign reinit = sw_ug || slv_reset;
    // Update disable blocks the shadow load, counter still wraps
    assign upd = !ctrl[`ATB_CTRL_UD]
                 && (reinit || ((ovf || udf) && rep_cnt == 8'h0));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt     <= `ATB_RST_ZERO;
            dir     <= 1'b0;
            psc_cnt <= `ATB_RST_ZERO;
        end else if (reinit) begin
            cnt     <= ctrl[`ATB_CTRL_DIR] && !ctrl[`ATB_CTRL_CMS] ? arr_pre : 16'h0;
            dir     <= ctrl[`ATB_CTRL_DIR] && !ctrl[`ATB_CTRL_CMS];
            psc_cnt <= `ATB_RST_ZERO;
        end else begin
            if (wr && adr_i == `ATB_OFS_CNT) begin
                cnt <= cnt_wr[15:0];
            end else begin
                cnt <= next_cnt;
            end
            dir <= next_dir;
            if (prescaler_clock && gate && ctrl[`ATB_CTRL_CEN]) begin
                psc_cnt <= tick ? 16'h0 : psc_cnt + 16'h1;
            end
        end
    end

    // Shadows only move on an update, so software may rewrite them at any time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psc_act <= `ATB_RST_ZERO;
            arr_act <= `ATB_RST_ARR;
            rep_act <= 8'h0;
            rep_cnt <= 8'h0;
        end else begin
            if (upd) begin
                psc_act <= psc_pre;
                arr_act <= arr_pre;
                rep_act <= rep_pre;
            end
            if (upd && reinit) begin
                rep_cnt <= rep_pre;
            end else if (ovf || udf) begin
                rep_cnt <= rep_cnt != 8'h0 ? rep_cnt - 8'h1
                           : (upd ? rep_pre : rep_act);
            end
        end
    end

    // ----------------------------------------
    // Control and preload registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl    <= 4'h0;
            smc     <= 15'h0;
            chcfg   <= 8'h0;
            psc_pre <= `ATB_RST_ZERO;
            arr_pre <= `ATB_RST_ARR;
            rep_pre <= 8'h0;
        end else begin
            if (wr && adr_i == `ATB_OFS_CTRL && sel_i[0]) begin
                ctrl <= dat_i[3:0];
            end
            if (slv_start) begin
                ctrl[`ATB_CTRL_CEN] <= 1'b1;
            end
            if (wr && adr_i == `ATB_OFS_SMC) begin
                smc <= smc_wr[14:0];
            end
            if (wr && adr_i == `ATB_OFS_CHCFG && sel_i[0]) begin
                chcfg <= dat_i[7:0];
            end
            if (wr && adr_i == `ATB_OFS_PSC) begin
                psc_pre <= psc_wr[15:0];
            end
            if (wr && adr_i == `ATB_OFS_ARR) begin
                arr_pre <= arr_wr[15:0];
            end
            if (wr && adr_i == `ATB_OFS_REP && sel_i[0]) begin
                rep_pre <= dat_i[7:0];
            end
        end
    end

    // ----------------------------------------
    // Status flags and event outputs
    // ----------------------------------------
    logic [3:0] sts_set;
    logic [3:0] sts_clr;
    logic       trg_evt;

    assign trg_evt = (trg_rise && sm != ATB_SM_OFF) || sw_tg;
    assign sts_set = {break_event_i, capture_compare_event_i, trg_evt, upd};
    assign sts_clr = (wr && adr_i == `ATB_OFS_STS && sel_i[0]) ? dat_i[3:0] : 4'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sts <= 4'h0;
        end else begin
            sts <= (sts & ~sts_clr) | sts_set; // Set beats a same-cycle clear
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_down_o                <= 1'b0;
            overrun_o                   <= 1'b0;
            underrun_o                  <= 1'b0;
            update_event_o              <= 1'b0;
            trigger_interrupt_o         <= 1'b0;
            capture_compare_interrupt_o <= 1'b0;
            break_interrupt_o           <= 1'b0;
            slave_trigger_input_o       <= 1'b0;
            channel_one_double_edge_o   <= 1'b0;
            filtered_polarised_input_o  <= 4'h0;
            external_trigger_filtered_o <= 1'b0;
        end else begin
            count_down_o                <= next_dir;
            overrun_o                   <= ovf;
            underrun_o                  <= udf;
            update_event_o              <= upd;
            trigger_interrupt_o         <= trg_evt;
            capture_compare_interrupt_o <= capture_compare_event_i;
            break_interrupt_o           <= break_event_i;
            slave_trigger_input_o       <= slave_trigger_input;
            channel_one_double_edge_o   <= ded;
            filtered_polarised_input_o  <= fout[3:0];
            external_trigger_filtered_o <= fout[4];
        end
    end

    assign count_value_o = cnt; // Counter flop drives the port directly
endmodule
`default_nettype wire

// *** atb_params.svh ***
`ifndef ATB_PARAMS_SVH
`define ATB_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ATB_OFS_CTRL  6'h00
`define ATB_OFS_SMC   6'h04
`define ATB_OFS_CHCFG 6'h08
`define ATB_OFS_STS   6'h0c
`define ATB_OFS_EVGEN 6'h10
`define ATB_OFS_CNT   6'h14
`define ATB_OFS_PSC   6'h18
`define ATB_OFS_ARR   6'h1c
`define ATB_OFS_REP   6'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATB_CTRL_CEN  0
`define ATB_CTRL_UD   1
`define ATB_CTRL_DIR  2
`define ATB_CTRL_CMS  3
`define ATB_SMC_SM    2:0
`define ATB_SMC_TS    6:3
`define ATB_SMC_ECE   7
`define ATB_SMC_ETPS  9:8
`define ATB_SMC_ETP   10
`define ATB_SMC_ETF   14:11
`define ATB_CH_POL    3:0
`define ATB_CH_FILT   7:4
`define ATB_STS_UIF   0
`define ATB_STS_TIF   1
`define ATB_STS_CCIF  2
`define ATB_STS_BIF   3
`define ATB_EV_UG     0
`define ATB_EV_TG     1
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATB_RST_ARR   16'hffff
`define ATB_RST_ZERO  16'h0000
`endif

// *** atb_pkg.sv ***
`default_nettype none
package atb_pkg;
    typedef enum logic [2:0] {
        ATB_SM_OFF   = 3'b000,
        ATB_SM_EXT1  = 3'b001,
        ATB_SM_RESET = 3'b010,
        ATB_SM_GATED = 3'b011,
        ATB_SM_TRIG  = 3'b100
    } atb_slave_mode_e;
    typedef enum logic [3:0] {
        ATB_TS_ITR0 = 4'h0,
        ATB_TS_ITR1 = 4'h1,
        ATB_TS_ITR2 = 4'h2,
        ATB_TS_ITR3 = 4'h3,
        ATB_TS_DEDG = 4'h4,
        ATB_TS_CH1  = 4'h5,
        ATB_TS_CH2  = 4'h6,
        ATB_TS_CH3  = 4'h7,
        ATB_TS_CH4  = 4'h8,
        ATB_TS_EXTERNAL_TRIGGER_FILTERED = 4'h9
    } atb_trig_sel_e;
endpackage
`default_nettype wire

// *** atb_timebase_checker.sv ***
`default_nettype none
module atb_timebase_checker (
    // Bus and clock
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [5:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // Time base and events
    input wire logic [15:0] count_value_o,
    input wire logic        count_down_o,
    input wire logic        overrun_o,
    input wire logic        underrun_o,
    input wire logic        capture_compare_event_i,
    input wire logic        capture_compare_interrupt_o,
    input wire logic        break_event_i,
    input wire logic        break_interrupt_o,
    input wire logic [3:0]  filtered_polarised_input_o,
    input wire logic        channel_one_double_edge_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       en_q;
    logic [2:0] sm_q;
    // Enable and slave mode as last written; hardware starts are not seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
            sm_q <= 3'h0;
        end else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0]) begin
            if (adr_i == 6'h00) en_q <= dat_i[0];
            if (adr_i == 6'h04) sm_q <= dat_i[2:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    a_bus_answer: assert property (s_req |=> ack_o ##1 !ack_o)
        else $error("bus answer missing or long");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_hold_off: assert property (
        !en_q && sm_q == 3'h0 && !(cyc_i && stb_i && we_i) |=> $stable(count_value_o))
        else $error("counter moved while disabled");
    a_up_overrun: assert property (overrun_o |-> !count_down_o)
        else $error("overrun while counting down");
    a_down_underrun: assert property (underrun_o |-> count_down_o)
        else $error("underrun while counting up");
    a_one_event: assert property (!(overrun_o && underrun_o))
        else $error("overrun and underrun together");
    a_break_irq: assert property (break_interrupt_o |-> $past(break_event_i))
        else $error("break report without cause");
    a_cc_irq: assert property (
        capture_compare_interrupt_o |-> $past(capture_compare_event_i))
        else $error("capture report without cause");
    a_edge_pulse: assert property (
        $changed(filtered_polarised_input_o[0]) |-> ##[0:3] channel_one_double_edge_o)
        else $error("channel one edge not reported");
endmodule
bind atb_timebase atb_timebase_checker chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .ack_o, .count_value_o, .count_down_o, .overrun_o,
    .underrun_o, .capture_compare_event_i, .capture_compare_interrupt_o,
    .break_event_i, .break_interrupt_o, .filtered_polarised_input_o,
    .channel_one_double_edge_o);
`default_nettype wire

// *** atb_far_side.sv ***
`default_nettype none
module atb_far_side (
    input  wire logic  clk_i,
    output logic [3:0] channel_pin_o,
    output logic       external_trigger_pin_o,
    output logic [3:0] internal_trigger_input_o,
    output logic       capture_compare_event_o,
    output logic       break_event_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        channel_pin_o = 4'h0;
        external_trigger_pin_o = 1'b0;
        internal_trigger_input_o = 4'h0;
        capture_compare_event_o = 1'b0;
        break_event_o = 1'b0;
    end
    task automatic drive(input int k, input logic v);
        case (k)
            0: internal_trigger_input_o[0] <= v;
            1: external_trigger_pin_o <= v;
            2: channel_pin_o[0] <= v;
            3: break_event_o <= v;
            default: capture_compare_event_o <= v;
        endcase
    endtask
    // Pin pulses stay wide enough to pass the synchroniser
    task automatic pulse(input int k, input int n);
        int w;
        w = (k > 2) ? 1 : 6;
        repeat (n) begin
            @(posedge clk_i);
            drive(k, 1'b1);
            repeat (w) @(posedge clk_i);
            drive(k, 1'b0);
            repeat (w) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// *** test_advanced_timer_timebase_clocking.sv ***
`default_nettype none
module test_advanced_timer_timebase_clocking;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [5:0]  adr_i = 6'h00;
    logic [31:0] dat_i = 32'h0, dat_o, r1, r2;
    logic [15:0] count_value_o;
    logic [3:0]  channel_pin_i, internal_trigger_input_i, filtered_polarised_input_o;
    logic        ack_o, count_down_o, overrun_o, underrun_o, update_event_o;
    logic        external_trigger_pin_i, capture_compare_event_i, break_event_i;
    logic        trigger_interrupt_o, capture_compare_interrupt_o, break_interrupt_o;
    logic        slave_trigger_input_o, channel_one_double_edge_o;
    logic        external_trigger_filtered_o;
    wire  [2:0]  evs = {update_event_o, underrun_o, overrun_o};
    int          fail_count = 0, comparisons = 0, c, ups, ovs, expn, i;
    int          smc[3] = '{32'h001, 32'h080, 32'h029}, num[3] = '{5, 3, 2};
    atb_timebase dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf),
        .dat_i, .dat_o, .ack_o, .channel_pin_i, .external_trigger_pin_i,
        .internal_trigger_input_i, .capture_compare_event_i, .break_event_i,
        .count_value_o, .count_down_o, .overrun_o, .underrun_o, .update_event_o,
        .trigger_interrupt_o, .capture_compare_interrupt_o, .break_interrupt_o,
        .slave_trigger_input_o, .channel_one_double_edge_o,
        .filtered_polarised_input_o, .external_trigger_filtered_o);
    atb_far_side far (.clk_i, .channel_pin_o(channel_pin_i),
        .external_trigger_pin_o(external_trigger_pin_i),
        .internal_trigger_input_o(internal_trigger_input_i),
        .capture_compare_event_o(capture_compare_event_i), .break_event_o(break_event_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    // Request held until ack is seen at a rising edge; data taken and released there
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) begin
            fail_count++;
            close_out();
        end
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        check(what, e, r);
    endtask
    task automatic wait_ev(input int w, output int n);
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (evs[w] !== 1'b1 && n < 800);
        if (n >= 800) begin
            fail_count++;
            close_out();
        end
    endtask
    task automatic period(input string what, input int w, input int e);
        int n;
        wait_ev(w, n);
        wait_ev(w, n);
        check(what, e, n);
    endtask
    task automatic count_ev(input int n);
        ups = 0;
        ovs = 0;
        repeat (n) begin
            @(negedge clk_i);
            ups += (update_event_o === 1'b1);
            ovs += (overrun_o === 1'b1);
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("counter reset", 6'h14, 32'h0);
        rd_chk("reload reset", 6'h1c, 32'hffff);
        wr(6'h20, 32'h1ab);
        rd_chk("repetition width", 6'h20, 32'hab);
        rd_chk("unmapped", 6'h24, 32'h0);
        $display("test reset done");
        wr(6'h20, 32'h0);
        wr(6'h1c, 32'h3);
        wr(6'h10, 32'h1);
        wr(6'h00, 32'h1);
        period("up period", 0, 4);
        wr(6'h18, 32'h2);
        period("prescaled period", 0, 12);
        wr(6'h18, 32'h0);
        wr(6'h20, 32'h2);
        wait_ev(2, c);
        count_ev(120);
        check("updates per repeat", 10, ups);
        check("overruns per repeat", 30, ovs);
        wr(6'h00, 32'h3);
        count_ev(100);
        check("updates disabled", 0, ups);
        check("overruns disabled", 1, ovs > 0);
        $display("test up done");
        wr(6'h00, 32'h5);
        @(negedge clk_i);
        check("direction", 1, count_down_o);
        period("down period", 1, 4);
        wr(6'h00, 32'h4);
        wb(1'b0, 6'h14, 32'h0, r1);
        wb(1'b0, 6'h14, 32'h0, r2);
        check("held count", r1, r2);
        wr(6'h00, 32'h9);
        period("center period", 0, 6);
        wr(6'h00, 32'h0);
        $display("test down done");
        wr(6'h1c, 32'hffff);
        wr(6'h10, 32'h1);
        expn = 0;
        for (i = 0; i < 3; i++) begin
            wr(6'h04, smc[i]);
            wr(6'h00, 32'h1);
            far.pulse(i, num[i]);
            repeat (10) @(posedge clk_i);
            expn += num[i];
            rd_chk("source count", 6'h14, expn);
        end
        far.pulse(3, 1);
        far.pulse(4, 1);
        rd_chk("status flags", 6'h0c, 32'hf);
        wr(6'h0c, 32'hf);
        wr(6'h10, 32'h2);
        rd_chk("status after clear", 6'h0c, 32'h2);
        $display("test sources done");
        close_out();
    end
endmodule
`default_nettype wire
